// ===== core/sbd_fifo.sv
// Small valid/ready FIFO for transmit characters
module sbd_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];     // Storage words
    logic [AW-1:0]    wr_q, wr_d;        // Write pointer
    logic [AW-1:0]    rd_q, rd_d;        // Read pointer
    logic [CW-1:0]    cnt_q, cnt_d;      // Fill level
    logic             push, pop;

    // Honest flags from the fill level
    assign o_in_ready  = (cnt_q != CW'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign o_out_data  = mem_q[rd_q];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    // Pointer and level updates, wrapping at DEPTH
    always_comb begin
        wr_d  = wr_q;
        rd_d  = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Data words need no reset
    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_in_data;
        end
    end
endmodule

// ===== core/sbd_map.svh
// Register indices, field positions, reset values and counts
`ifndef SBD_MAP_SVH
`define SBD_MAP_SVH
`define SBD_IDX_STATUS 8'h50
`define SBD_IDX_DATA   8'h51
`define SBD_IDX_BAUD   8'h52
`define SBD_IDX_CTRL1  8'h53
`define SBD_IDX_CTRL2  8'h54
`define SBD_IDX_ERX    8'h55
`define SBD_IDX_ETX    8'h56
`define SBD_PSC_MSB    7
`define SBD_PSC_LSB    6
`define SBD_TX_MSB     5
`define SBD_TX_LSB     3
`define SBD_RX_MSB     2
`define SBD_RX_LSB     0
`define SBD_ST_TDRE    7
`define SBD_ST_TC      6
`define SBD_ST_RDRF    5
`define SBD_RST_STATUS 8'hC0
`define SBD_RST_BAUD   8'h00
`define SBD_RST_EXT    8'h00
`define SBD_RST_CTRL   8'h00
`define SBD_PSC_F0     4'h1
`define SBD_PSC_F1     4'h3
`define SBD_PSC_F2     4'h4
`define SBD_PSC_F3     4'hD
`define SBD_X16_LAST   4'hF
`define SBD_FIFO_DEPTH 4
`endif

// ===== core/sbd_pkg.sv
// Types and decode functions of the serial baud and data block
`include "sbd_map.svh"
package sbd_pkg;
    // Register selected by an APB address
    typedef enum logic [2:0] {
        SBD_R_STATUS = 3'b000,
        SBD_R_DATA   = 3'b001,
        SBD_R_BAUD   = 3'b010,
        SBD_R_CTRL1  = 3'b011,
        SBD_R_CTRL2  = 3'b100,
        SBD_R_ERX    = 3'b101,
        SBD_R_ETX    = 3'b110,
        SBD_R_NONE   = 3'b111
    } sbd_reg_e;

    // Word-aligned byte address to register
    function automatic sbd_reg_e sbd_decode(input logic [11:0] addr);
        sbd_reg_e r;
        r = SBD_R_NONE;
        if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
            case (addr[9:2])
                `SBD_IDX_STATUS: r = SBD_R_STATUS;
                `SBD_IDX_DATA:   r = SBD_R_DATA;
                `SBD_IDX_BAUD:   r = SBD_R_BAUD;
                `SBD_IDX_CTRL1:  r = SBD_R_CTRL1;
                `SBD_IDX_CTRL2:  r = SBD_R_CTRL2;
                `SBD_IDX_ERX:    r = SBD_R_ERX;
                `SBD_IDX_ETX:    r = SBD_R_ETX;
                default:         r = SBD_R_NONE;
            endcase
        end
        return r;
    endfunction

    // First prescaler code to division factor
    function automatic logic [3:0] sbd_psc_factor(input logic [1:0] sel);
        logic [3:0] f;
        unique case (sel)
            2'b00: f = `SBD_PSC_F0;
            2'b01: f = `SBD_PSC_F1;
            2'b10: f = `SBD_PSC_F2;
            2'b11: f = `SBD_PSC_F3;
        endcase
        return f;
    endfunction
endpackage

// ===== core/sbd_rate_div.sv
// Rate generator for one direction: prescaler, divisor, x16, extended
module sbd_rate_div (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [1:0] i_psc_sel,
    input  wire logic [2:0] i_div_sel,
    input  wire logic [7:0] i_ext,
    output logic            o_sample_tick,
    output logic            o_bit_tick
);
    import sbd_pkg::*;

    logic [3:0] psc_f;                  // First prescale factor
    logic [7:0] div_f;                  // Power-of-two divisor
    logic [3:0] psc_q, psc_d;           // Prescale counter
    logic [6:0] dv_q, dv_d;             // Divisor counter
    logic [3:0] s16_q, s16_d;           // Divide-by-16 stage
    logic [7:0] ex_q, ex_d;             // Extended counter
    logic       psc_tick, smp, x16, ext_hit, bit_d;

    // Compare with >= so a smaller new setting never hangs a counter
    always_comb begin
        psc_f    = sbd_psc_factor(i_psc_sel);
        div_f    = 8'h01 << i_div_sel;
        psc_tick = psc_q >= (psc_f - 4'h1);
        smp      = psc_tick && ({1'b0, dv_q} >= (div_f - 8'h01));
        x16      = smp && (s16_q == `SBD_X16_LAST);
        ext_hit  = ex_q >= (i_ext - 8'h01);
        // Zero keeps the conventional path
        bit_d    = (i_ext == 8'h00) ? x16 : (x16 && ext_hit);
        psc_d    = psc_tick ? 4'h0 : psc_q + 4'h1;
        dv_d     = dv_q;
        s16_d    = s16_q;
        ex_d     = ex_q;
        if (psc_tick) begin
            dv_d = smp ? 7'h00 : dv_q + 7'h01;
        end
        if (smp) begin
            s16_d = s16_q + 4'h1;
        end
        if (x16) begin
            ex_d = (ext_hit || i_ext == 8'h00) ? 8'h00 : ex_q + 8'h01;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            psc_q         <= 4'h0;
            dv_q          <= 7'h00;
            s16_q         <= 4'h0;
            ex_q          <= 8'h00;
            o_sample_tick <= 1'b0;
            o_bit_tick    <= 1'b0;
        end else begin
            psc_q         <= psc_d;
            dv_q          <= dv_d;
            s16_q         <= s16_d;
            ex_q          <= ex_d;
            o_sample_tick <= smp;
            o_bit_tick    <= bit_d;
        end
    end

    // Helper: gaps between ticks, and whether settings held since
    logic [11:0] sgap_q;
    logic [23:0] bgap_q;
    logic        sseen_q, bseen_q, chg;
    logic [12:0] set_q;                 // Settings held at the last edge
    // Registered copy flags a new setting for exactly one cycle
    assign chg = ({i_psc_sel, i_div_sel, i_ext} != set_q);
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sgap_q  <= 12'h000;
            bgap_q  <= 24'h000000;
            sseen_q <= 1'b0;
            bseen_q <= 1'b0;
            set_q   <= 13'h0000;
        end else begin
            sgap_q  <= o_sample_tick ? 12'h001 : sgap_q + 12'h001;
            bgap_q  <= o_bit_tick ? 24'h000001 : bgap_q + 24'h000001;
            sseen_q <= chg ? 1'b0 : (sseen_q || o_sample_tick);
            bseen_q <= chg ? 1'b0 : (bseen_q || o_bit_tick);
            set_q   <= {i_psc_sel, i_div_sel, i_ext};
        end
    end

    a_sample_period: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_sample_tick && sseen_q && !chg |-> sgap_q == 12'(psc_f) * 12'(div_f))
        else $error("sample tick period wrong");
    a_bit_period: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_bit_tick && bseen_q && !chg |-> bgap_q == 24'(psc_f) * 24'(div_f) * 24'h10
            * ((i_ext == 8'h00) ? 24'h1 : 24'(i_ext)))
        else $error("bit tick period wrong");
    a_ext_bypass: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_ext == 8'h00 && x16 |=> o_bit_tick)
        else $error("zero extended factor must not divide");
endmodule

// ===== core/sbd_top.sv
// APB data and baud registers with transmit FIFO and rate generators
`include "sbd_map.svh"
module sbd_top #(
    parameter int FIFO_DEPTH = `SBD_FIFO_DEPTH
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic [7:0]       o_tx_char,
    output logic             o_tx_char_valid,
    input  wire logic        i_tx_char_take,
    input  wire logic [7:0]  i_rx_char,
    input  wire logic        i_rx_char_valid,
    output logic             o_tx_sample_tick,
    output logic             o_tx_bit_tick,
    output logic             o_rx_sample_tick,
    output logic             o_rx_bit_tick,
    output logic [7:0]       o_ctrl1,
    output logic [7:0]       o_ctrl2
);
    import sbd_pkg::*;
    // Each register is one byte in the low end of its word;
    // read data bits 31:8 are always zero

    sbd_reg_e    sel;                  // Decoded register
    logic        acc;                  // Access phase seen
    logic        done;                 // Transfer completes this edge
    logic        prep;                 // Answer prepared this edge
    logic        stall;                // Data write blocked by full holding
    logic        pready_d, pslverr_d;
    logic [31:0] prdata_d;
    logic        pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0]  status;               // Live status byte

    logic [7:0]  baud_q, baud_d;       // Baud rate select
    logic [7:0]  erx_q, erx_d;         // Extended rx factor
    logic [7:0]  etx_q, etx_d;         // Extended tx factor
    logic [7:0]  c1_q, c1_d;           // Control one, plain storage
    logic [7:0]  c2_q, c2_d;           // Control two, plain storage

    logic [7:0]  txh_q, txh_d;         // Transmit holding register
    logic        txf_q, txf_d;         // Transmit holding full
    logic [7:0]  rxh_q, rxh_d;         // Receive holding register
    logic        rxf_q, rxf_d;         // Receive holding full
    logic        rd_clr;               // Data read empties rx holding

    logic        fi_ready, fo_valid, fo_pop;
    logic [7:0]  fo_data;
    logic [7:0]  txo_q, txo_d;         // Output stage character
    logic        txv_q, txv_d;         // Output stage valid

    // Bus decode; one wait state before every answer, more while a data write stalls
    // Registered answer keeps bus outputs on flops,
    // at the price of one extra cycle per transfer
    always_comb begin
        sel       = sbd_decode(i_paddr);
        acc       = i_psel && i_penable;
        done      = acc && pready_q;
        // Back-pressure: a data write waits while the holding is still full
        stall     = i_pwrite && sel == SBD_R_DATA && txf_q;
        prep      = acc && !pready_q && !stall;
        rd_clr    = prep && !i_pwrite && sel == SBD_R_DATA;
        pready_d  = prep;
        pslverr_d = prep && sel == SBD_R_NONE;
        prdata_d  = prdata_q;
        status    = 8'h00;
        status[`SBD_ST_TDRE] = !txf_q;
        status[`SBD_ST_TC]   = !txf_q && !fo_valid && !txv_q;
        status[`SBD_ST_RDRF] = rxf_q;
        if (prep && !i_pwrite) begin
            unique case (sel)
                SBD_R_STATUS: prdata_d = {24'h000000, status};
                SBD_R_DATA:   prdata_d = {24'h000000, rxh_q};
                SBD_R_BAUD:   prdata_d = {24'h000000, baud_q};
                SBD_R_CTRL1:  prdata_d = {24'h000000, c1_q};
                SBD_R_CTRL2:  prdata_d = {24'h000000, c2_q};
                SBD_R_ERX:    prdata_d = {24'h000000, erx_q};
                SBD_R_ETX:    prdata_d = {24'h000000, etx_q};
                SBD_R_NONE:   prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    // Configuration writes take effect at the completing edge
    // Control bytes are plain storage in this block
    always_comb begin
        baud_d = baud_q;
        erx_d  = erx_q;
        etx_d  = etx_q;
        c1_d   = c1_q;
        c2_d   = c2_q;
        if (done && i_pwrite) begin
            case (sel)
                SBD_R_BAUD:  baud_d = i_pwdata[7:0];
                SBD_R_ERX:   erx_d  = i_pwdata[7:0];
                SBD_R_ETX:   etx_d  = i_pwdata[7:0];
                SBD_R_CTRL1: c1_d   = i_pwdata[7:0];
                SBD_R_CTRL2: c2_d   = i_pwdata[7:0];
                default:     baud_d = baud_q;  // Status and data elsewhere
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            baud_q <= `SBD_RST_BAUD;
            erx_q  <= `SBD_RST_EXT;
            etx_q  <= `SBD_RST_EXT;
            c1_q   <= `SBD_RST_CTRL;
            c2_q   <= `SBD_RST_CTRL;
        end else begin
            baud_q <= baud_d;
            erx_q  <= erx_d;
            etx_q  <= etx_d;
            c1_q   <= c1_d;
            c2_q   <= c2_d;
        end
    end

    // Holding registers; an arriving character beats a clearing read
    // A full holding stalls the next data write instead of
    // dropping it, so no accepted character is lost
    always_comb begin
        txh_d = txh_q;
        txf_d = txf_q;
        rxh_d = rxh_q;
        rxf_d = rxf_q;
        if (txf_q && fi_ready) begin
            txf_d = 1'b0;
        end
        if (done && i_pwrite && sel == SBD_R_DATA) begin
            txh_d = i_pwdata[7:0];
            txf_d = 1'b1;
        end
        if (rd_clr) begin
            rxf_d = 1'b0;
        end
        // A second character while full is still stored: newest wins
        if (i_rx_char_valid) begin
            rxh_d = i_rx_char;
            rxf_d = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            txh_q <= 8'h00;
            txf_q <= 1'b0;
            rxh_q <= 8'h00;
            rxf_q <= 1'b0;
        end else begin
            txh_q <= txh_d;
            txf_q <= txf_d;
            rxh_q <= rxh_d;
            rxf_q <= rxf_d;
        end
    end

    // Queue between holding register and outgoing shift path
    // Absorbs a burst of writes while the shifter is busy
    sbd_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_txq (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_in_valid  (txf_q),
        .o_in_ready  (fi_ready),
        .i_in_data   (txh_q),
        .o_out_valid (fo_valid),
        .i_out_ready (fo_pop),
        .o_out_data  (fo_data)
    );

    // Registered output stage; shift path takes with i_tx_char_take
    always_comb begin
        fo_pop = fo_valid && (!txv_q || i_tx_char_take);
        txo_d  = txo_q;
        txv_d  = txv_q;
        if (fo_pop) begin
            txo_d = fo_data;
            txv_d = 1'b1;
        end else if (i_tx_char_take) begin
            txv_d = 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            txo_q <= 8'h00;
            txv_q <= 1'b0;
        end else begin
            txo_q <= txo_d;
            txv_q <= txv_d;
        end
    end

    // Independent generators per direction, shared prescale code
    // Separate counters: a new tx divisor never
    // disturbs a character arriving on the rx side
    sbd_rate_div u_txrate (
        .i_core_clk    (i_core_clk),
        .i_rst         (i_rst),
        .i_psc_sel     (baud_q[`SBD_PSC_MSB:`SBD_PSC_LSB]),
        .i_div_sel     (baud_q[`SBD_TX_MSB:`SBD_TX_LSB]),
        .i_ext         (etx_q),
        .o_sample_tick (o_tx_sample_tick),
        .o_bit_tick    (o_tx_bit_tick)
    );

    // Receive side: own divisor field and extended factor
    sbd_rate_div u_rxrate (
        .i_core_clk    (i_core_clk),
        .i_rst         (i_rst),
        .i_psc_sel     (baud_q[`SBD_PSC_MSB:`SBD_PSC_LSB]),
        .i_div_sel     (baud_q[`SBD_RX_MSB:`SBD_RX_LSB]),
        .i_ext         (erx_q),
        .o_sample_tick (o_rx_sample_tick),
        .o_bit_tick    (o_rx_bit_tick)
    );

    // Outputs straight from flops, free of decode glitches
    assign o_prdata        = prdata_q;
    assign o_pready        = pready_q;
    assign o_pslverr       = pslverr_q;
    assign o_tx_char       = txo_q;
    assign o_tx_char_valid = txv_q;
    assign o_ctrl1         = c1_q;
    assign o_ctrl2         = c2_q;

    // Checks next to the logic they guard
    // A data read is judged where its answer is prepared,
    // a data write at the edge where it completes
    sequence s_data_wr;
        done && i_pwrite && sel == SBD_R_DATA;
    endsequence
    sequence s_data_rd;
        prep && !i_pwrite && sel == SBD_R_DATA;
    endsequence

    a_wr_loads_tx: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_data_wr |=> txf_q && txh_q == $past(i_pwdata[7:0])
            && (rxh_q == $past(rxh_q) || $past(i_rx_char_valid)))
        else $error("data write did not load only tx holding");
    a_rd_gets_rx: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_data_rd |=> o_pready && o_prdata[7:0] == $past(rxh_q)
            && txh_q == $past(txh_q))
        else $error("data read did not return rx holding");
    a_rx_capture: assert property (@(posedge i_core_clk) disable iff (i_rst)
        i_rx_char_valid |=> rxf_q && rxh_q == $past(i_rx_char))
        else $error("received character not held");
    a_rx_keeps: assert property (@(posedge i_core_clk) disable iff (i_rst)
        rxf_q && !i_rx_char_valid && !rd_clr |=> rxf_q && $stable(rxh_q))
        else $error("rx holding lost without a read");
    // Empty path: FIFO holds it one edge later, output stage the next
    a_tx_drains: assert property (@(posedge i_core_clk) disable iff (i_rst)
        txf_q && !txv_q && !fo_valid |-> ##1 (!txf_q && fo_valid)
            ##1 (txv_q && txo_q == $past(txh_q, 2)))
        else $error("tx holding did not reach shift path");
    // Baud select and both extended factors must be zero straight out of reset
    a_reset_zero: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $past(i_rst) |-> baud_q == 8'h00 && erx_q == 8'h00 && etx_q == 8'h00)
        else $error("rate registers not zero after reset");
    a_baud_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        done && i_pwrite && sel == SBD_R_BAUD |=> baud_q == $past(i_pwdata[7:0]))
        else $error("baud register write lost");
    // Back-pressure holds the answer while holding is full
    a_stall_full: assert property (@(posedge i_core_clk) disable iff (i_rst)
        acc && stall && !pready_q |=> !o_pready)
        else $error("data write answered while holding full");
endmodule

// ===== verification/sbd_partner.sv
// Far-side model: outgoing shifter sink and incoming character source
module sbd_partner (
    input  wire logic       i_core_clk,
    input  wire logic       i_stall,
    input  wire logic [7:0] i_tx_char,
    input  wire logic       i_tx_char_valid,
    output logic            o_tx_char_take,
    output logic [7:0]      o_rx_char,
    output logic            o_rx_char_valid
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [7:0] got_q[$]; // Characters shifted out, oldest first

    // Shifter takes a character whenever one stands and it is not busy
    assign o_tx_char_take = i_tx_char_valid && !i_stall;

    // Capture at the same edge that the take is sampled
    always @(posedge i_core_clk) begin
        if (o_tx_char_take === 1'b1) begin
            got_q.push_back(i_tx_char);
        end
    end

    // Idle at time zero
    initial begin
        o_rx_char       = 8'h00;
        o_rx_char_valid = 1'b0;
    end

    // One completed character for one cycle; the bus then shows junk
    task automatic send(input logic [7:0] c);
        @(posedge i_core_clk);
        o_rx_char       <= c;
        o_rx_char_valid <= 1'b1;
        @(posedge i_core_clk);
        o_rx_char       <= ~c; // Not the old value, so stale reads show
        o_rx_char_valid <= 1'b0;
    endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the serial baud and data block
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [11:0] A_ST   = 12'h140; // Status
    localparam logic [11:0] A_DATA = 12'h144; // Shared data word
    localparam logic [11:0] A_BAUD = 12'h148; // Baud select
    localparam logic [11:0] A_CR1  = 12'h14C; // Control one
    localparam logic [11:0] A_CR2  = 12'h150; // Control two
    localparam logic [11:0] A_ERX  = 12'h154; // Extended rx factor
    localparam logic [11:0] A_ETX  = 12'h158; // Extended tx factor

    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic        stall;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [7:0]  tx_char;
    wire         tx_valid;
    wire         take;
    wire  [7:0]  rx_char;
    wire         rx_valid;
    wire  [3:0]  tk;       // tx sample, tx bit, rx sample, rx bit
    wire  [7:0]  ctrl1;
    wire  [7:0]  ctrl2;
    int          error_cnt = 0;
    int          checks = 0;
    int          prf[4] = '{1, 3, 4, 13}; // First prescaler factors

    sbd_top #(.FIFO_DEPTH(4)) i_sbd_top (
        .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_tx_char(tx_char),
        .o_tx_char_valid(tx_valid), .i_tx_char_take(take), .i_rx_char(rx_char),
        .i_rx_char_valid(rx_valid), .o_tx_sample_tick(tk[0]), .o_tx_bit_tick(tk[1]),
        .o_rx_sample_tick(tk[2]), .o_rx_bit_tick(tk[3]), .o_ctrl1(ctrl1), .o_ctrl2(ctrl2));

    sbd_partner i_sbd_partner (
        .i_core_clk(clk), .i_stall(stall), .i_tx_char(tx_char),
        .i_tx_char_valid(tx_valid), .o_tx_char_take(take),
        .o_rx_char(rx_char), .o_rx_char_valid(rx_valid));

    // Free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Count every comparison, report each mismatch at once
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
            error_cnt++;
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 2000);
        if (n >= 2000) begin // A hung slave ends the run
            error_cnt++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    // Read and compare data, with no error response expected
    task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, exp, r);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask

    // Bounded wait for the far side to collect n characters
    task automatic wait_q(input int n);
        int k;
        for (k = 0; k < 500 && i_sbd_partner.got_q.size() < n; k++) @(posedge clk);
        chk("tx_count", n, i_sbd_partner.got_q.size());
    endtask

    // Period of one tick output, after letting a new setting settle
    task automatic per(input int s, input int exp);
        int n;
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (tk[s] !== 1'b1 && n < 4000);
        end
        chk("tick_period", exp, n);
    endtask

    task automatic t_reset();
        rchk("status", A_ST, 32'hC0);
        rchk("baud", A_BAUD, 32'h0);
        rchk("ext_rx", A_ERX, 32'h0);
        rchk("ext_tx", A_ETX, 32'h0);
        rchk("ctrl2", A_CR2, 32'h0);
    endtask

    // Unmapped word errors, status ignores writes, control is storage
    task automatic t_unmapped();
        logic [31:0] r;
        logic        e;
        apb(1'b0, 12'h15C, 32'h0, r, e);
        chk("unmapped_err", 32'h1, {31'h0, e});
        chk("unmapped_data", 32'h0, r);
        wr(A_ST, 32'h0);
        rchk("status_ro", A_ST, 32'hC0);
        wr(A_CR1, 32'h5A);
        wr(A_CR2, 32'hA5);
        @(posedge clk);
        chk("ctrl1_out", 32'h5A, {24'h0, ctrl1});
        chk("ctrl2_out", 32'hA5, {24'h0, ctrl2});
        rchk("ctrl1", A_CR1, 32'h5A);
        rchk("ctrl2", A_CR2, 32'hA5);
    endtask

    // Fill holding and FIFO while the shifter stalls, then drain in order
    task automatic t_tx();
        stall <= 1'b1;
        for (int i = 0; i < 6; i++) wr(A_DATA, 32'hA0 + i);
        rchk("status_full", A_ST, 32'h00);
        fork
            wr(A_DATA, 32'hA6); // Held in wait states until holding drains
            begin
                repeat (30) @(posedge clk);
                stall <= 1'b0;
            end
        join
        wait_q(7);
        for (int i = 0; i < 7; i++) chk("tx_char", 32'hA0 + i, i_sbd_partner.got_q[i]);
        rchk("status_idle", A_ST, 32'hC0);
    endtask

    // Received characters held apart from transmit ones; newest wins
    task automatic t_rx();
        i_sbd_partner.send(8'h3C);
        rchk("status_rx", A_ST, 32'hE0);
        wr(A_DATA, 32'h11);
        rchk("rx_data", A_DATA, 32'h3C);
        wait_q(8);
        chk("tx_char", 32'h11, i_sbd_partner.got_q[7]);
        rchk("status_read", A_ST, 32'hC0);
        i_sbd_partner.send(8'h55);
        i_sbd_partner.send(8'h66);
        rchk("rx_overrun", A_DATA, 32'h66);
    endtask

    // Rate ticks over every prescaler code, then the extended path
    task automatic t_rates();
        for (int p = 0; p < 4; p++) begin
            wr(A_BAUD, {24'h0, p[1:0], 3'h1, 3'h2});
            per(0, prf[p] * 2);
            per(2, prf[p] * 4);
            per(1, prf[p] * 32);
        end
        wr(A_ETX, 32'h3);
        per(1, 13 * 32 * 3);
        per(3, 13 * 64);
        wr(A_ERX, 32'h2);
        per(3, 13 * 64 * 2);
        per(2, 13 * 4);
        wr(A_ETX, 32'h0);
        per(1, 13 * 32);
    endtask

    // Single closing point of the run
    task automatic give_verdict();
        $display("Comparisons %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Reset, then the scenarios in turn
    initial begin
        rst     = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h0;
        pwdata  = 32'h0;
        stall   = 1'b0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_unmapped();
        t_tx();
        t_rx();
        t_rates();
        give_verdict();
    end
endmodule
